// [rtl/bbfs_sequencer.sv]
`timescale 1ns/1ns
// What this block does
// - on enable start buck if terminal-1 undervoltage clear, else boost.
// - both terminal undervoltage flags: hold buck, fault, soft-start low, no switching.
// - buck goes boost on terminal-1 undervoltage or qualified terminal-2 overvoltage.
// - boost goes buck on terminal-2 undervoltage or qualified terminal-1 overvoltage.
// - both overvoltage flags qualified together: buck, fault, soft-start low, stop.
// - any supply undervoltage forces buck, fault, soft-start low, no switching.
// - direction pin released in buck, pulled down in boost.
// - an externally driven direction level selects the mode; device follows it.
// - fault is open-drain; while set switching stops and soft-start pulled low.
// - sharing ground switch closes only when enabled and diagnostics passed.
// - on shutdown or fault stop sharing current and open sharing ground switch.
// - route terminal-2 current to buck outputs in buck, boost outputs in boost.
// - in boost start timer charge when limit regulates and drain-source is high.
// - timer at upper threshold turns the protection switch off.
// - then cool down, cycling timer between thresholds, counting the cycles.
// - on the 32nd lower-threshold crossing turn the protection switch back on.
// - diagnostic state leaves as active-low open-drain serial stream on sync clock.
// - sync takes an external clock; held high enables spread spectrum, low disables.
// - regulation compares buck or boost output-limit node with the sharing node.
// - external buck direction plus terminal-2 overvoltage gives fault, not a mode change.
// - external boost direction plus terminal-2 undervoltage gives fault and stop.
module bbfs_sequencer
	import bbfs_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic [AXI_AW-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [AXI_AW-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 enablePin,
	input  wire logic                 term1_undervolt_flag,
	input  wire logic                 term2_undervolt_flag,
	input  wire logic                 term1_overvolt_flag,
	input  wire logic                 term2_overvolt_flag,
	input  wire logic                 gate_supply_uv,
	input  wire logic                 internal_supply_uv,
	input  wire logic                 diagPassed,
	input  wire logic                 outLimitInReg,
	input  wire logic                 prot1DsHigh,
	input  wire logic                 soaTimerAboveHi,
	input  wire logic                 soaTimerBelowLo,
	input  wire logic                 syncPin,
	input  wire logic                 direction_select_pin_in,
	output logic                      direction_select_pin_out,
	output logic                      direction_select_pin_oe,
	output logic                      faultOut,
	output logic                      faultOe,
	output logic                      reportOut,
	output logic                      reportOe,
	output logic                      softStartPullLow,
	output logic                      switchEnable,
	output logic                      share_ground_switch,
	output logic                      shareSourceEnable,
	output logic                      routeBuckLimit,
	output logic                      routeBoostLimit,
	output logic                      shareRegBoost,
	output logic                      soaTimerCharge,
	output logic                      soaTimerDischarge,
	output logic                      soaCoolDown,
	output logic                      prot1_gate_drive,
	output logic                      spreadSpectrumEn
);
	bbfs_core_st_t       r_reg;
	bbfs_core_st_t       r_next;
	logic [NUM_IN-1:0]   pinS;
	logic [QUAL_NUM-1:0] qDone;
	logic                en;
	logic                uv1;
	logic                uv2;
	logic                ov1;
	logic                ov2;
	logic                supplyUv;
	logic                dir;
	logic                syncS;

	assign pinS = r_reg.s2;
	assign en = pinS[IN_ENABLE];
	assign uv1 = pinS[IN_UV1];
	assign uv2 = pinS[IN_UV2];
	assign ov1 = pinS[IN_OV1];
	assign ov2 = pinS[IN_OV2];
	assign supplyUv = pinS[IN_GATE_UV] | pinS[IN_INT_UV];
	assign dir = pinS[IN_DIR];
	assign syncS = pinS[IN_SYNC];

	for (genvar g = 0; g < QUAL_NUM; g++) begin : gQual
		bbfs_qual_if qIf();
		assign qIf.flag = r_reg.qFlag[g];
		assign qIf.clear = r_reg.qClr;
		assign qDone[g] = qIf.done;
		bbfs_qualify uQual (
			.core_clk (core_clk),
			.rst      (rst),
			.q        (qIf.cnt)
		);
	end

	always_comb begin
		logic [REPORT_W-1:0] word;
		bbfs_mode_t          nm;
		logic                flt;
		logic                settled;
		logic                running;
		logic                healthy;
		word = '0;
		nm = r_reg.mode;
		flt = 1'b0;
		settled = (r_reg.settle == '0);
		running = 1'b0;
		healthy = 1'b0;
		r_next = r_reg;
		r_next.s1 = {syncPin, soaTimerBelowLo, soaTimerAboveHi, prot1DsHigh, outLimitInReg,
			diagPassed, direction_select_pin_in, internal_supply_uv, gate_supply_uv,
			term2_overvolt_flag, term1_overvolt_flag, term2_undervolt_flag,
			term1_undervolt_flag, enablePin};
		r_next.s2 = r_reg.s1;

		// direction selection
		if (!en) begin
			nm = MD_OFF;
		end else begin
			unique case (r_reg.mode)
				MD_OFF: begin
					if (r_reg.ctrlExt) begin
						nm = dir ? MD_BUCK : MD_BOOST;
					end else begin
						nm = uv1 ? MD_BOOST : MD_BUCK;
					end
				end
				MD_BUCK: begin
					if (r_reg.ctrlExt ? !dir
						: (uv1 | qDone[Q_OV2] | (settled & !dir))) begin
						nm = MD_BOOST;
					end
				end
				MD_BOOST: begin
					if (r_reg.ctrlExt ? dir
						: (uv2 | qDone[Q_OV1] | (settled & dir))) begin
						nm = MD_BUCK;
					end
				end
			endcase
			if (r_reg.ctrlExt && r_reg.mode == MD_BUCK && ov2) begin
				flt = 1'b1;
			end
			if (r_reg.ctrlExt && r_reg.mode == MD_BOOST && uv2) begin
				flt = 1'b1;
			end
			if (supplyUv || (uv1 && uv2) || qDone[Q_BOTH]) begin
				nm = MD_BUCK;
				flt = 1'b1;
			end
		end
		r_next.mode = nm;
		r_next.fault = flt;
		r_next.qClr = (nm != r_reg.mode);
		r_next.qFlag[Q_OV1] = ov1 & (nm == MD_BOOST) & !r_reg.ctrlExt;
		r_next.qFlag[Q_OV2] = ov2 & (nm == MD_BUCK) & !r_reg.ctrlExt;
		r_next.qFlag[Q_BOTH] = ov1 & ov2 & en;
		// pin readback ignored while the pull-up recovers
		if (nm != r_reg.mode) begin
			r_next.settle = DIR_SETTLE_CYC;
		end else if (!settled) begin
			r_next.settle = r_reg.settle - 1'b1;
		end

		running = (nm != MD_OFF);
		healthy = running & !flt & pinS[IN_DIAG];
		r_next.dirPull = (nm == MD_BOOST);
		r_next.switchEn = running & !flt;
		r_next.ssPull = !running | flt;
		r_next.shareGnd = healthy;
		r_next.shareSrc = healthy;
		r_next.routeBuck = (nm == MD_BUCK);
		r_next.routeBoost = (nm == MD_BOOST);

		// protection switch timer
		unique case (r_reg.tst)
			T_IDLE: begin
				if (nm == MD_BOOST && pinS[IN_LIM_REG] && pinS[IN_DS_HIGH]) begin
					r_next.tst = T_CHARGE;
					r_next.tChg = 1'b1;
					r_next.tDis = 1'b0;
				end
			end
			T_CHARGE: begin
				if (pinS[IN_TMR_HI]) begin
					r_next.tst = T_COOL_DN;
					r_next.gateOff = 1'b1;
					r_next.cool = 1'b1;
					r_next.coolCnt = '0;
					r_next.tChg = 1'b0;
					r_next.tDis = 1'b1;
				end else if (!(pinS[IN_LIM_REG] && pinS[IN_DS_HIGH])) begin
					r_next.tst = T_IDLE;
					r_next.tChg = 1'b0;
					r_next.tDis = 1'b1;
				end
			end
			T_COOL_DN: begin
				if (pinS[IN_TMR_LO]) begin
					if (r_reg.coolCnt == COOL_LAST) begin
						r_next.tst = T_IDLE;
						r_next.gateOff = 1'b0;
						r_next.cool = 1'b0;
					end else begin
						r_next.tst = T_COOL_UP;
						r_next.coolCnt = r_reg.coolCnt + 1'b1;
						r_next.tChg = 1'b1;
						r_next.tDis = 1'b0;
					end
				end
			end
			T_COOL_UP: begin
				if (pinS[IN_TMR_HI]) begin
					r_next.tst = T_COOL_DN;
					r_next.tChg = 1'b0;
					r_next.tDis = 1'b1;
				end
			end
		endcase
		if (!en) begin
			r_next.tst = T_IDLE;
			r_next.gateOff = 1'b0;
			r_next.cool = 1'b0;
			r_next.coolCnt = '0;
			r_next.tChg = 1'b0;
			r_next.tDis = 1'b1;
		end
		r_next.gate = running & !flt & !r_next.gateOff;

		// sync pin: clock or strap level
		r_next.syncPrev = syncS;
		if (syncS && !r_reg.syncPrev) begin
			r_next.quietCnt = '0;
			r_next.extClk = 1'b1;
			r_next.spread = 1'b0;
		end else if (r_reg.quietCnt != SYNC_QUIET_CYC) begin
			r_next.quietCnt = r_reg.quietCnt + 1'b1;
		end else begin
			r_next.extClk = 1'b0;
			r_next.spread = syncS;
		end

		// diagnostic stream, one bit per sync rising edge
		word = {r_reg.fault, uv1, uv2, ov1, ov2, supplyUv, !pinS[IN_DIAG], r_reg.gateOff};
		if (syncS && !r_reg.syncPrev) begin
			r_next.rptIdx = r_reg.rptIdx + 1'b1;
			if (r_reg.rptIdx == '0) begin
				r_next.rptOe = word[REPORT_W-1];
				r_next.rptShift = {word[REPORT_W-2:0], 1'b0};
			end else begin
				r_next.rptOe = r_reg.rptShift[REPORT_W-1];
				r_next.rptShift = {r_reg.rptShift[REPORT_W-2:0], 1'b0};
			end
		end

		// register bus
		if (s_axi_awvalid && r_reg.awRdy) begin
			r_next.awHave = 1'b1;
			r_next.awA = s_axi_awaddr;
			r_next.awRdy = 1'b0;
		end
		if (s_axi_wvalid && r_reg.wRdy) begin
			r_next.wHave = 1'b1;
			r_next.wD = s_axi_wdata;
			r_next.wS = s_axi_wstrb;
			r_next.wRdy = 1'b0;
		end
		if (r_reg.awHave && r_reg.wHave && !r_reg.bValid) begin
			r_next.awHave = 1'b0;
			r_next.wHave = 1'b0;
			r_next.bValid = 1'b1;
			r_next.bResp = RESP_OKAY;
			if (r_reg.awA[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) begin
				if (r_reg.wS[0]) begin
					r_next.ctrlExt = r_reg.wD[CTRL_EXT_DIR];
				end
			end else if (r_reg.awA[AXI_AW-1:2] != REG_STATUS[AXI_AW-1:2]) begin
				r_next.bResp = RESP_DECERR;
			end
		end
		if (r_reg.bValid && s_axi_bready) begin
			r_next.bValid = 1'b0;
			r_next.awRdy = 1'b1;
			r_next.wRdy = 1'b1;
		end
		if (s_axi_arvalid && r_reg.arRdy) begin
			r_next.arRdy = 1'b0;
			r_next.rValid = 1'b1;
			r_next.rResp = RESP_OKAY;
			if (s_axi_araddr[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) begin
				r_next.rData = {31'h00000000, r_reg.ctrlExt};
			end else if (s_axi_araddr[AXI_AW-1:2] == REG_STATUS[AXI_AW-1:2]) begin
				r_next.rData = {21'h000000, r_reg.spread, r_reg.extClk, r_reg.coolCnt,
					r_reg.gateOff, r_reg.fault, 2'(r_reg.mode)};
			end else begin
				r_next.rData = 32'h00000000;
				r_next.rResp = RESP_DECERR;
			end
		end
		if (r_reg.rValid && s_axi_rready) begin
			r_next.rValid = 1'b0;
			r_next.arRdy = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r_reg <= CORE_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign s_axi_awready = r_reg.awRdy;
	assign s_axi_wready = r_reg.wRdy;
	assign s_axi_bresp = r_reg.bResp;
	assign s_axi_bvalid = r_reg.bValid;
	assign s_axi_arready = r_reg.arRdy;
	assign s_axi_rdata = r_reg.rData;
	assign s_axi_rresp = r_reg.rResp;
	assign s_axi_rvalid = r_reg.rValid;
	assign direction_select_pin_out = 1'b0;
	assign direction_select_pin_oe = r_reg.dirPull;
	assign faultOut = 1'b0;
	assign faultOe = r_reg.fault;
	assign reportOut = 1'b0;
	assign reportOe = r_reg.rptOe;
	assign softStartPullLow = r_reg.ssPull;
	assign switchEnable = r_reg.switchEn;
	assign share_ground_switch = r_reg.shareGnd;
	assign shareSourceEnable = r_reg.shareSrc;
	assign routeBuckLimit = r_reg.routeBuck;
	assign routeBoostLimit = r_reg.routeBoost;
	assign shareRegBoost = r_reg.routeBoost;
	assign soaTimerCharge = r_reg.tChg;
	assign soaTimerDischarge = r_reg.tDis;
	assign soaCoolDown = r_reg.cool;
	assign prot1_gate_drive = r_reg.gate;
	assign spreadSpectrumEn = r_reg.spread;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence sCoolLast;
		r_reg.tst == T_COOL_DN && pinS[IN_TMR_LO] && r_reg.coolCnt == COOL_LAST;
	endsequence
	sequence sTripHi;
		r_reg.tst == T_CHARGE && pinS[IN_TMR_HI];
	endsequence

	AST_START_DIR: assert property (en && r_reg.mode == MD_OFF && !r_reg.ctrlExt
		&& !supplyUv && !uv2 && !qDone[Q_BOTH] |=> r_reg.mode == (uv1 ? MD_BOOST : MD_BUCK))
		else $error("wrong start mode");
	AST_SUPPLY_UV: assert property (en && supplyUv |=>
		r_reg.mode == MD_BUCK && faultOe && softStartPullLow && !switchEnable)
		else $error("supply undervoltage not forcing buck fault");
	AST_BOTH_UV: assert property (en && uv1 && uv2 |=> r_reg.mode == MD_BUCK && faultOe)
		else $error("double undervoltage not faulted");
	AST_FAULT_STOP: assert property (faultOe |-> !switchEnable && softStartPullLow)
		else $error("switching while faulted");
	AST_SHARE_OPEN: assert property (faultOe || r_reg.mode == MD_OFF
		|-> !share_ground_switch && !shareSourceEnable)
		else $error("sharing active during fault or shutdown");
	AST_SHARE_DIAG: assert property ($rose(share_ground_switch) |-> $past(pinS[IN_DIAG]))
		else $error("ground switch closed without diagnostics");
	AST_DIR_PULL: assert property (direction_select_pin_oe
		== (r_reg.mode == MD_BOOST))
		else $error("direction pin pull not matching mode");
	AST_TRIP: assert property ((en && !faultOe) and sTripHi |=> !prot1_gate_drive
		##1 r_reg.gateOff)
		else $error("protection switch not turned off");
	AST_COOL_END: assert property (en and sCoolLast |=> r_reg.tst == T_IDLE
		&& !r_reg.gateOff)
		else $error("cool down did not end on last crossing");
	AST_EXT_OV: assert property (en && r_reg.ctrlExt && r_reg.mode == MD_BUCK && dir
		&& ov2 |=> faultOe && r_reg.mode == MD_BUCK)
		else $error("external buck overvoltage not faulted");
	AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
endmodule : bbfs_sequencer

// [rtl/bbfs_pkg.sv]
package bbfs_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int QUAL_COUNT = 1024;
	localparam int QUAL_W = 11;
	localparam logic [QUAL_W-1:0] QUAL_LAST = QUAL_W'(QUAL_COUNT - 1);
	localparam int COOL_CYCLES = 32;
	localparam logic [4:0] COOL_LAST = 5'(COOL_CYCLES - 1);
	localparam int SYNC_SLOW_PERIOD_NS = 12500;
	localparam logic [11:0] SYNC_QUIET_CYC = 12'(SYNC_SLOW_PERIOD_NS / CLK_PERIOD_NS + 1);
	localparam int DIR_SETTLE_NS = 1000;
	localparam logic [7:0] DIR_SETTLE_CYC =
		8'((DIR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam int AXI_AW = 8;
	localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam int CTRL_EXT_DIR = 0;

	localparam int IN_ENABLE = 0;
	localparam int IN_UV1 = 1;
	localparam int IN_UV2 = 2;
	localparam int IN_OV1 = 3;
	localparam int IN_OV2 = 4;
	localparam int IN_GATE_UV = 5;
	localparam int IN_INT_UV = 6;
	localparam int IN_DIR = 7;
	localparam int IN_DIAG = 8;
	localparam int IN_LIM_REG = 9;
	localparam int IN_DS_HIGH = 10;
	localparam int IN_TMR_HI = 11;
	localparam int IN_TMR_LO = 12;
	localparam int IN_SYNC = 13;
	localparam int NUM_IN = 14;

	localparam int QUAL_NUM = 3;
	localparam int Q_OV1 = 0;
	localparam int Q_OV2 = 1;
	localparam int Q_BOTH = 2;
	localparam int REPORT_W = 8;

	typedef enum logic [1:0] {MD_OFF, MD_BUCK, MD_BOOST} bbfs_mode_t;
	typedef enum logic [1:0] {T_IDLE, T_CHARGE, T_COOL_DN, T_COOL_UP} bbfs_tmr_t;

	typedef struct packed {
		logic [QUAL_W-1:0] cnt;
		logic              done;
	} bbfs_qual_st_t;
	localparam bbfs_qual_st_t QUAL_RST = '0;

	typedef struct packed {
		logic [NUM_IN-1:0]   s1;
		logic [NUM_IN-1:0]   s2;
		logic                syncPrev;
		logic [11:0]         quietCnt;
		logic                extClk;
		logic                spread;
		bbfs_mode_t          mode;
		logic                fault;
		logic [7:0]          settle;
		logic [QUAL_NUM-1:0] qFlag;
		logic                qClr;
		bbfs_tmr_t           tst;
		logic [4:0]          coolCnt;
		logic                gateOff;
		logic [REPORT_W-1:0] rptShift;
		logic [2:0]          rptIdx;
		logic                rptOe;
		logic                dirPull;
		logic                switchEn;
		logic                ssPull;
		logic                shareGnd;
		logic                shareSrc;
		logic                routeBuck;
		logic                routeBoost;
		logic                tChg;
		logic                tDis;
		logic                cool;
		logic                gate;
		logic                ctrlExt;
		logic                awHave;
		logic                wHave;
		logic [AXI_AW-1:0]   awA;
		logic [31:0]         wD;
		logic [3:0]          wS;
		logic                awRdy;
		logic                wRdy;
		logic                bValid;
		logic [1:0]          bResp;
		logic                arRdy;
		logic                rValid;
		logic [31:0]         rData;
		logic [1:0]          rResp;
	} bbfs_core_st_t;
	localparam bbfs_core_st_t CORE_RST = '{mode: MD_OFF, tst: T_IDLE, tDis: 1'b1,
		ssPull: 1'b1, awRdy: 1'b1, wRdy: 1'b1, arRdy: 1'b1, default: '0};
endpackage : bbfs_pkg

// [rtl/bbfs_qual_if.sv]
`timescale 1ns/1ns
interface bbfs_qual_if;
	logic flag;
	logic clear;
	logic done;
	modport ctl (output flag, output clear, input done);
	modport cnt (input flag, input clear, output done);
endinterface : bbfs_qual_if

// [rtl/bbfs_qualify.sv]
`timescale 1ns/1ns
module bbfs_qualify
	import bbfs_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst,
	bbfs_qual_if.cnt  q
);
	bbfs_qual_st_t r_reg;
	bbfs_qual_st_t r_next;

	always_comb begin
		r_next = r_reg;
		if (q.clear || !q.flag) begin
			r_next.cnt = '0;
			r_next.done = 1'b0;
		end else if (!r_reg.done) begin
			if (r_reg.cnt == QUAL_LAST) begin
				r_next.done = 1'b1;
			end else begin
				r_next.cnt = r_reg.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r_reg <= QUAL_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign q.done = r_reg.done;

	AST_QUAL_FULL: assert property (@(posedge core_clk) disable iff (rst)
		$rose(r_reg.done) |-> $past(r_reg.cnt) == QUAL_LAST)
		else $error("qualify done without full count");
	AST_QUAL_DROP: assert property (@(posedge core_clk) disable iff (rst)
		!q.flag |=> r_reg.cnt == '0 && !r_reg.done)
		else $error("qualify count kept after flag drop");
endmodule : bbfs_qualify

// [tb/bbfs_partner.sv]
`timescale 1ns/1ns
module bbfs_partner (
	input  wire logic core_clk,
	input  wire logic dirOe,
	input  wire logic extDrive,
	input  wire logic extLevel,
	output logic      dirLevel,
	input  wire logic tmrCharge,
	input  wire logic tmrDischarge,
	input  wire logic coolDown,
	output logic      aboveHi,
	output logic      belowLo,
	output logic [7:0] lowCrossings
);
	int lvl = 0;
	int cnt = 0;
	// pull-up unless pulled low; a peer driving the node wins
	assign dirLevel = extDrive ? extLevel : !dirOe;
	assign aboveHi = lvl >= 14;
	assign belowLo = lvl <= 4;
	assign lowCrossings = 8'(cnt);
	always @(posedge core_clk) begin
		if (tmrCharge && lvl < 20)
			lvl <= lvl + 1;
		else if (tmrDischarge && lvl > 0)
			lvl <= lvl - 1;
		if (coolDown && tmrDischarge && lvl == 5)
			cnt <= cnt + 1;
	end
endmodule : bbfs_partner

// [tb/test_bbfs_sequencer.sv]
`timescale 1ns/1ns
module test_bbfs_sequencer;
	import bbfs_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, enablePin = 0, term1_undervolt_flag = 0, term2_undervolt_flag = 0;
	logic term1_overvolt_flag = 0, term2_overvolt_flag = 0, gate_supply_uv = 0;
	logic internal_supply_uv = 0, diagPassed = 0, outLimitInReg = 0, prot1DsHigh = 0;
	logic syncPin = 0, extDrive = 0, extLevel = 0, soaTimerAboveHi, soaTimerBelowLo;
	logic direction_select_pin_in, direction_select_pin_out, direction_select_pin_oe;
	logic faultOut, faultOe, reportOut, reportOe, softStartPullLow, switchEnable;
	logic share_ground_switch, shareSourceEnable, routeBuckLimit, routeBoostLimit;
	logic shareRegBoost, soaTimerCharge, soaTimerDischarge, soaCoolDown, prot1_gate_drive;
	logic spreadSpectrumEn;
	logic [7:0] nCross;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;

	always #2 core_clk = ~core_clk;

	bbfs_sequencer u_bbfs_sequencer (.*);
	bbfs_partner u_bbfs_partner (.core_clk, .dirOe(direction_select_pin_oe), .extDrive,
		.extLevel, .dirLevel(direction_select_pin_in), .tmrCharge(soaTimerCharge),
		.tmrDischarge(soaTimerDischarge), .coolDown(soaCoolDown), .aboveHi(soaTimerAboveHi),
		.belowLo(soaTimerBelowLo), .lowCrossings(nCross));

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 20000) begin
			n_fail++;
			$display("MISMATCH timeout expected done seen running");
			give_verdict();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic chk(input string what, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %b seen %b", what, e, g);
		end
	endtask : chk

	function automatic logic [1:0] expMode(input logic uv1, input logic uv2);
		return (uv1 && !uv2) ? 2'h2 : 2'h1;
	endfunction : expMode

	function automatic logic [REPORT_W-1:0] rptWord(input logic f, input logic u1,
		input logic u2, input logic dg);
		return {f, u1, u2, 3'b000, !dg, 1'b0};
	endfunction : rptWord

	task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axiWr

	task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axiRd

	task automatic chkMode(input logic [1:0] m);
		logic [31:0] d;
		logic [1:0] r;
		axiRd(REG_STATUS, d, r);
		chk("mode", 1'b1, d[1:0] === m);
		chk("routeBuck", m == 2'h1, routeBuckLimit);
		chk("routeBoost", m == 2'h2, routeBoostLimit);
		chk("dirPullDown", m == 2'h2, direction_select_pin_oe);
		chk("shareRegBoost", m == 2'h2, shareRegBoost);
	endtask : chkMode

	task automatic chkFault(input logic f);
		chk("fault", f, faultOe);
		chk("ssPull", f, softStartPullLow);
		chk("switching", !f, switchEnable);
		if (f) begin
			chk("shareGnd", 1'b0, share_ground_switch);
			chk("shareSrc", 1'b0, shareSourceEnable);
		end
	endtask : chkFault

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [REPORT_W-1:0] w;
		void'($urandom(76));
		cyc(8);
		rst <= 1'b0;
		cyc(1);
		chk("rstSoftStart", 1'b1, softStartPullLow);
		chk("rstSwitch", 1'b0, switchEnable);
		axiRd(8'h08 + 8'(($urandom % 62) * 4), d, r);
		chk("unmapped", 1'b1, r === RESP_DECERR);
		axiWr(REG_CTRL, 32'h1, r);
		axiRd(REG_CTRL, d, r);
		chk("ctrlBack", 1'b1, d[0] === 1'b1 && r === RESP_OKAY);
		axiWr(REG_CTRL, 32'h0, r);
		s_axi_wstrb <= 4'hE;
		axiWr(REG_CTRL, 32'h1, r);
		s_axi_wstrb <= 4'hF;
		axiRd(REG_CTRL, d, r);
		chk("ctrlStrb", 1'b0, d[0]);
		enablePin <= 1'b1;
		cyc(8);
		chkMode(expMode(0, 0));
		chk("shareGndNoDiag", 1'b0, share_ground_switch);
		diagPassed <= 1'b1;
		cyc(8);
		chk("shareGndDiag", 1'b1, share_ground_switch);
		chkFault(1'b0);
		term1_undervolt_flag <= 1'b1;
		cyc(8);
		chkMode(expMode(1, 0));
		term1_undervolt_flag <= 1'b0;
		term2_undervolt_flag <= 1'b1;
		cyc(8);
		chkMode(expMode(0, 1));
		term1_undervolt_flag <= 1'b1;
		cyc(8);
		chkMode(expMode(1, 1));
		chkFault(1'b1);
		w = rptWord(1'b1, 1'b1, 1'b1, diagPassed);
		for (int b = 0; b < REPORT_W; b++) begin
			syncPin <= 1'b1;
			cyc(210);
			syncPin <= 1'b0;
			cyc(210);
			chk("reportBit", w[REPORT_W-1-b], reportOe);
		end
		axiRd(REG_STATUS, d, r);
		chk("extClk", 1'b1, d[9]);
		syncPin <= 1'b1;
		cyc(3140);
		chk("spreadOn", 1'b1, spreadSpectrumEn);
		syncPin <= 1'b0;
		cyc(8);
		chk("spreadOff", 1'b0, spreadSpectrumEn);
		term2_undervolt_flag <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			term1_undervolt_flag <= 1'b1;
			cyc(8);
			gate_supply_uv <= (k == 0);
			internal_supply_uv <= (k == 1);
			cyc(8);
			chkMode(2'h1);
			chkFault(1'b1);
			term1_undervolt_flag <= 1'b0;
			cyc(4);
			gate_supply_uv <= 1'b0;
			internal_supply_uv <= 1'b0;
			cyc(300);
		end
		// an early drop must restart the persistence count
		term2_overvolt_flag <= 1'b1;
		cyc(200 + $urandom % 700);
		term2_overvolt_flag <= 1'b0;
		cyc(4);
		term2_overvolt_flag <= 1'b1;
		cyc(1000);
		chkMode(2'h1);
		cyc(40);
		chkMode(2'h2);
		term2_overvolt_flag <= 1'b0;
		chk("gateOn", 1'b1, prot1_gate_drive);
		outLimitInReg <= 1'b1;
		prot1DsHigh <= 1'b1;
		for (int i = 0; i < 200 && prot1_gate_drive; i++)
			cyc(1);
		chk("gateOff", 1'b0, prot1_gate_drive);
		chk("coolDown", 1'b1, soaCoolDown);
		outLimitInReg <= 1'b0;
		prot1DsHigh <= 1'b0;
		for (int i = 0; i < 3000 && !prot1_gate_drive; i++)
			cyc(1);
		chk("crossings", 1'b1, nCross === 8'(COOL_CYCLES));
		chk("gateBack", 1'b1, prot1_gate_drive);
		term1_overvolt_flag <= 1'b1;
		cyc(1040);
		chkMode(2'h1);
		term1_overvolt_flag <= 1'b0;
		cyc(300);
		term1_overvolt_flag <= 1'b1;
		term2_overvolt_flag <= 1'b1;
		cyc(1040);
		chkMode(2'h1);
		chkFault(1'b1);
		term1_overvolt_flag <= 1'b0;
		term2_overvolt_flag <= 1'b0;
		cyc(300);
		axiWr(REG_CTRL, 32'h1, r);
		extDrive <= 1'b1;
		cyc(300);
		chkMode(2'h2);
		extLevel <= 1'b1;
		cyc(300);
		chkMode(2'h1);
		term2_overvolt_flag <= 1'b1;
		cyc(8);
		chkMode(2'h1);
		chkFault(1'b1);
		term2_overvolt_flag <= 1'b0;
		extLevel <= 1'b0;
		cyc(300);
		term2_undervolt_flag <= 1'b1;
		cyc(8);
		chkMode(2'h2);
		chkFault(1'b1);
		term2_undervolt_flag <= 1'b0;
		extDrive <= 1'b0;
		axiWr(REG_CTRL, 32'h0, r);
		enablePin <= 1'b0;
		cyc(8);
		chkMode(2'h0);
		chk("offSrc", 1'b0, shareSourceEnable);
		chk("offGnd", 1'b0, share_ground_switch);
		give_verdict();
	end
endmodule : test_bbfs_sequencer
